// file: design/phy_diag_map.svh
// register indexes, field positions, reset values of the diagnostic register bank
// assumes byte address on the bus is four times the index below
`ifndef PHY_DIAG_MAP_SVH
`define PHY_DIAG_MAP_SVH

// register indexes
`define IDX_MAC_IF_TAIL 10'h017
`define IDX_INTERRUPT_STATUS_THREE 10'h018
`define IDX_ST_COUNT_GAP 10'h01b
`define IDX_ST_PKT_LEN 10'h01c
`define IDX_REFLECT_CTRL 10'h01e
`define IDX_PHY_RESET_CTRL 10'h01f
`define IDX_LINK_STATUS 10'h133
`define IDX_FAULT_RESULT 10'h16b
`define IDX_PEAK_LOC_12 10'h180
`define IDX_PEAK_LOC_34 10'h181
`define IDX_PEAK_TYPE 10'h18a

// field positions
`define BIT_UNDERFLOW 2
`define BIT_PEND_POR 12
`define BIT_PEND_NOFRAME 11
`define BIT_PEND_SLEEP 8
`define BIT_EN_POR 4
`define BIT_EN_NOFRAME 3
`define BIT_EN_SLEEP 0
`define BIT_ERR_FREEZE 15
`define BIT_REFLECT_START 15
`define BIT_HW_RESET 15
`define BIT_SW_RESTART 14
`define BIT_STANDBY 7

// reset values and fixed reserved read values
`define EB_SIZE_RST 2'h1
`define INT_EN_RST 3'h4
`define IPG_RST 8'h7d
`define PKT_LEN_RST 11'h5ee
`define MAC_IF_RSV 16'h4048
`define LINK_RSV 16'h05e0

`endif

// file: design/phy_diag_pkg.sv
// types shared by the diagnostic register bank
// assumes the map header carries all numbers
package phy_diag_pkg;

   // status and events from the phy core, same clock
   typedef struct packed {
      logic por_done;
      logic no_frame;
      logic sleep_sig;
      logic rx_underflow;
      logic prbs_err;
      logic err_cnt_continuous;
      logic link_up;
      logic scr_lock;
      logic local_rx_ok;
      logic remote_rx_ok;
   } core_status_s;

   // results from the reflectometry engine
   typedef struct packed {
      logic done;
      logic fail;
      logic fault;
      logic fault_short;
      logic [7:0] fault_loc;
      logic [3:0][7:0] peak_loc;
      logic [3:0] peak_neg;
   } reflect_result_s;

   // controls toward the phy core
   typedef struct packed {
      logic [1:0] eb_size;
      logic [2:0] eb_tol_bits;
      logic [9:0] ipg_bytes;
      logic [10:0] pkt_len;
      logic reflect_run;
      logic hw_reset;
      logic sw_restart;
      logic standby;
      logic irq;
   } core_ctrl_s;

   // whole state of the register bank
   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
      logic [1:0] eb_size;
      logic underflow_n;
      logic [2:0] int_pend;
      logic [2:0] int_en;
      logic [7:0] err_cnt;
      logic [7:0] err_frozen;
      logic [7:0] ipg;
      logic [10:0] pkt_len;
      logic reflect_start;
      logic reflect_done;
      logic reflect_fail;
      logic hw_rst;
      logic sw_rst;
      logic standby;
   } bank_state_s;

endpackage : phy_diag_pkg

// file: design/phy_diag_regs.sv
// diagnostic and control register bank of a single-pair ethernet phy
// assumes classic wishbone master on mclk and phy core inputs on the same clock
//
// Contract
// - buffer size field sets drift tolerance
// - underflow reads 0 after event, read clears
// - pending bits latch until status read
// - enables rw, por enable resets to 1
// - upper byte shows prbs errored byte count
// - write bit15 freezes count, clears counter
// - single mode count saturates at 0xff
// - gap equals value times four bytes
// - packet length from eleven-bit field
// - start bit self clears, zero means idle
// - done and fail bits set by measurement
// - hardware reset bit resets whole phy
// - software restart keeps register contents
// - standby bit selects standby mode
// - link status bit is live, unlatched
// - scrambler, local, remote status bits
// - fault flag and short/open type
// - fault location byte, valid with fault
// - four peak locations, two per register
// - peak polarity bits fourteen to eleven

`include "phy_diag_map.svh"

module phy_diag_regs
   import phy_diag_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // phy core side
   input wire core_status_s core_i,
   input wire reflect_result_s reflect_i,
   output core_ctrl_s ctrl_o
);

   ////////////////////////////////////////////////////////////////////////////
   // reset image of the state
   localparam bank_state_s RST_STATE = '{
      ack: 1'b0, rdata: 16'h0000, eb_size: `EB_SIZE_RST, underflow_n: 1'b1,
      int_pend: 3'h0, int_en: `INT_EN_RST, err_cnt: 8'h00, err_frozen: 8'h00,
      ipg: `IPG_RST, pkt_len: `PKT_LEN_RST, reflect_start: 1'b0,
      reflect_done: 1'b0, reflect_fail: 1'b0, hw_rst: 1'b0, sw_rst: 1'b0,
      standby: 1'b0};

   bank_state_s st_q;
   bank_state_s st_d;
   logic take;
   logic wr;
   logic rd;
   logic [9:0] idx;
   logic [15:0] wmask;
   logic [15:0] wval;
   logic [15:0] rval;
   logic [2:0] eb_tol;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode: one access taken per request, ack the next cycle
   assign take = wb_cyc_i & wb_stb_i & ~st_q.ack;
   assign wr = take & wb_we_i;
   assign rd = take & ~wb_we_i;
   assign idx = wb_adr_i[11:2];
   assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wval = wb_dat_i[15:0] & wmask;

   // read multiplexer, unmapped reads give zero
   always_comb begin
      case (idx)
         `IDX_MAC_IF_TAIL: begin
            rval = `MAC_IF_RSV | {13'h0000, st_q.underflow_n, st_q.eb_size};
         end
         `IDX_INTERRUPT_STATUS_THREE: begin
            rval = 16'h0000;
            rval[`BIT_PEND_POR] = st_q.int_pend[2];
            rval[`BIT_PEND_NOFRAME] = st_q.int_pend[1];
            rval[`BIT_PEND_SLEEP] = st_q.int_pend[0];
            rval[`BIT_EN_POR] = st_q.int_en[2];
            rval[`BIT_EN_NOFRAME] = st_q.int_en[1];
            rval[`BIT_EN_SLEEP] = st_q.int_en[0];
         end
         `IDX_ST_COUNT_GAP: rval = {st_q.err_frozen, st_q.ipg};
         `IDX_ST_PKT_LEN: rval = {5'h00, st_q.pkt_len};
         `IDX_REFLECT_CTRL: begin
            rval = {st_q.reflect_start, 13'h0000, st_q.reflect_done, st_q.reflect_fail};
         end
         `IDX_PHY_RESET_CTRL: begin
            rval = {st_q.hw_rst, st_q.sw_rst, 6'h00, st_q.standby, 7'h00};
         end
         `IDX_LINK_STATUS: begin
            rval = `LINK_RSV | {3'h0, core_i.link_up, 9'h000, core_i.scr_lock,
                                core_i.local_rx_ok, core_i.remote_rx_ok};
         end
         `IDX_FAULT_RESULT: begin
            rval = {6'h00, reflect_i.fault, reflect_i.fault_short, reflect_i.fault_loc};
         end
         `IDX_PEAK_LOC_12: rval = {reflect_i.peak_loc[1], reflect_i.peak_loc[0]};
         `IDX_PEAK_LOC_34: rval = {reflect_i.peak_loc[3], reflect_i.peak_loc[2]};
         `IDX_PEAK_TYPE: rval = {1'b0, reflect_i.peak_neg, 11'h000};
         default: rval = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_d = st_q;
      st_d.ack = take;
      if (take) begin
         st_d.rdata = rval;
      end
      // one-cycle pulses fall back by themselves
      st_d.hw_rst = 1'b0;
      st_d.sw_rst = 1'b0;

      // read clears first, hardware sets below win
      if (rd && idx == `IDX_INTERRUPT_STATUS_THREE) begin
         st_d.int_pend = 3'h0;
      end
      if (rd && idx == `IDX_MAC_IF_TAIL) begin
         st_d.underflow_n = 1'b1;
      end

      // register writes, byte lanes honoured, reserved bits dropped
      if (wr) begin
         case (idx)
            `IDX_MAC_IF_TAIL: begin
               if (wb_sel_i[0]) begin
                  st_d.eb_size = wval[1:0];
               end
            end
            `IDX_INTERRUPT_STATUS_THREE: begin
               if (wb_sel_i[0]) begin
                  st_d.int_en = {wval[`BIT_EN_POR], wval[`BIT_EN_NOFRAME],
                                 wval[`BIT_EN_SLEEP]};
               end
            end
            `IDX_ST_COUNT_GAP: begin
               if (wb_sel_i[0]) begin
                  st_d.ipg = wval[7:0];
               end
               if (wval[`BIT_ERR_FREEZE]) begin
                  st_d.err_frozen = st_q.err_cnt;
                  st_d.err_cnt = 8'h00;
               end
            end
            `IDX_ST_PKT_LEN: begin
               st_d.pkt_len = (st_q.pkt_len & ~wmask[10:0]) | wval[10:0];
            end
            `IDX_REFLECT_CTRL: begin
               if (wval[`BIT_REFLECT_START]) begin
                  st_d.reflect_start = 1'b1;
                  st_d.reflect_done = 1'b0;
                  st_d.reflect_fail = 1'b0;
               end
            end
            `IDX_PHY_RESET_CTRL: begin
               st_d.hw_rst = wval[`BIT_HW_RESET];
               st_d.sw_rst = wval[`BIT_SW_RESTART];
               if (wb_sel_i[0]) begin
                  st_d.standby = wval[`BIT_STANDBY];
               end
            end
            default: begin
            end
         endcase
      end

      // hardware events, set wins over any clear but a pending hardware reset
      if (core_i.por_done) begin
         st_d.int_pend[2] = 1'b1;
      end
      if (core_i.no_frame) begin
         st_d.int_pend[1] = 1'b1;
      end
      if (core_i.sleep_sig) begin
         st_d.int_pend[0] = 1'b1;
      end
      if (core_i.rx_underflow) begin
         st_d.underflow_n = 1'b0;
      end

      // prbs errored byte counter
      if (core_i.prbs_err) begin
         if (core_i.err_cnt_continuous || st_d.err_cnt != 8'hff) begin
            st_d.err_cnt = st_d.err_cnt + 8'h01;
         end else begin
            st_d.err_cnt = 8'hff;
         end
      end

      // measurement completion ends the run
      if (st_q.reflect_start && (reflect_i.done || reflect_i.fail)) begin
         st_d.reflect_start = 1'b0;
         st_d.reflect_done = 1'b1;
         st_d.reflect_fail = reflect_i.fail;
      end

      // pending hardware reset restores every register
      if (st_q.hw_rst) begin
         st_d = RST_STATE;
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= RST_STATE;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = {16'h0000, st_q.rdata};

   // tolerance decode of the buffer size field
   always_comb begin
      case (st_q.eb_size)
         2'h0: eb_tol = 3'h5;
         2'h1: eb_tol = 3'h2;
         2'h2: eb_tol = 3'h3;
         default: eb_tol = 3'h4;
      endcase
   end

   // control outputs straight from state
   assign ctrl_o.eb_size = st_q.eb_size;
   assign ctrl_o.eb_tol_bits = eb_tol;
   assign ctrl_o.ipg_bytes = {st_q.ipg, 2'b00};
   assign ctrl_o.pkt_len = st_q.pkt_len;
   assign ctrl_o.reflect_run = st_q.reflect_start;
   assign ctrl_o.hw_reset = st_q.hw_rst;
   assign ctrl_o.sw_restart = st_q.sw_rst;
   assign ctrl_o.standby = st_q.standby;
   assign ctrl_o.irq = |(st_q.int_pend & st_q.int_en);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_pend_latch: assert property (@(posedge mclk) disable iff (sys_rst)
      core_i.por_done && !st_q.hw_rst |=> st_q.int_pend[2] && (ctrl_o.irq || !st_q.int_en[2]))
      else $error("por done event not latched");

   chk_irq_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      ctrl_o.irq |-> (st_q.int_pend[0] && st_q.int_en[0]) || (st_q.int_pend[1]
         && st_q.int_en[1]) || (st_q.int_pend[2] && st_q.int_en[2]))
      else $error("irq without enabled pending bit");

   chk_underflow_flag: assert property (@(posedge mclk) disable iff (sys_rst)
      core_i.rx_underflow && !st_q.hw_rst |=> !st_q.underflow_n)
      else $error("underflow indication not set");

   chk_underflow_clear: assert property (@(posedge mclk) disable iff (sys_rst)
      rd && idx == `IDX_MAC_IF_TAIL && !core_i.rx_underflow |=> st_q.underflow_n)
      else $error("underflow indication not cleared by read");

   chk_pend_clear: assert property (@(posedge mclk) disable iff (sys_rst)
      rd && idx == `IDX_INTERRUPT_STATUS_THREE && !core_i.por_done && !core_i.no_frame && !core_i.sleep_sig
         |=> st_q.int_pend == 3'h0)
      else $error("pending bits not cleared by status read");

   chk_err_saturate: assert property (@(posedge mclk) disable iff (sys_rst)
      !core_i.err_cnt_continuous && st_q.err_cnt == 8'hff && !wr && !st_q.hw_rst
         |=> st_q.err_cnt == 8'hff)
      else $error("single mode count left 0xff");

   chk_err_freeze: assert property (@(posedge mclk) disable iff (sys_rst)
      wr && idx == `IDX_ST_COUNT_GAP && wval[`BIT_ERR_FREEZE] && !st_q.hw_rst
         |=> st_q.err_frozen == $past(st_q.err_cnt) && st_q.err_cnt <= 8'h01)
      else $error("error count not frozen and cleared");

   chk_reflect_end: assert property (@(posedge mclk) disable iff (sys_rst)
      st_q.reflect_start && reflect_i.done && !wr && !st_q.hw_rst
         |=> !st_q.reflect_start && st_q.reflect_done && !ctrl_o.reflect_run)
      else $error("measurement start not self cleared");

   chk_hw_reset: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(st_q.hw_rst) |=> st_q.ipg == `IPG_RST && st_q.pkt_len == `PKT_LEN_RST
         && st_q.int_en == `INT_EN_RST && !st_q.hw_rst)
      else $error("hardware reset did not restore registers");

   chk_sw_restart: assert property (@(posedge mclk) disable iff (sys_rst)
      st_q.sw_rst && !st_q.hw_rst && !wr |=> !st_q.sw_rst && $stable(st_q.ipg)
         && $stable(st_q.pkt_len) && $stable(st_q.standby))
      else $error("software restart disturbed registers");

   chk_ack_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   chk_tol_decode: assert property (@(posedge mclk) disable iff (sys_rst)
      ctrl_o.eb_tol_bits == (st_q.eb_size == 2'h0 ? 3'h5 : {1'b0, st_q.eb_size} + 3'h1))
      else $error("drift tolerance decode wrong");

   chk_en_write: assert property (@(posedge mclk) disable iff (sys_rst)
      wr && idx == `IDX_INTERRUPT_STATUS_THREE && wb_sel_i[0] && !st_q.hw_rst
         |=> st_q.int_en[2] == $past(wb_dat_i[`BIT_EN_POR])
         && st_q.int_en[0] == $past(wb_dat_i[`BIT_EN_SLEEP]))
      else $error("interrupt enables not written");

   chk_ipg_scale: assert property (@(posedge mclk) disable iff (sys_rst)
      wr && idx == `IDX_ST_COUNT_GAP && wb_sel_i[0] && !st_q.hw_rst
         |=> ctrl_o.ipg_bytes == 10'($past(wb_dat_i[7:0])) * 10'h004)
      else $error("gap length not four bytes per step");

   chk_pkt_len: assert property (@(posedge mclk) disable iff (sys_rst)
      wr && idx == `IDX_ST_PKT_LEN && wb_sel_i[1:0] == 2'h3 && !st_q.hw_rst
         |=> ctrl_o.pkt_len == $past(wb_dat_i[10:0]))
      else $error("packet length not written");

   chk_start_run: assert property (@(posedge mclk) disable iff (sys_rst)
      wr && idx == `IDX_REFLECT_CTRL && wval[`BIT_REFLECT_START] && !st_q.hw_rst
         && !reflect_i.done && !reflect_i.fail
         |=> ctrl_o.reflect_run && !st_q.reflect_done && !st_q.reflect_fail)
      else $error("measurement start not taken");

   chk_reflect_fail: assert property (@(posedge mclk) disable iff (sys_rst)
      st_q.reflect_start && reflect_i.fail && !wr && !st_q.hw_rst
         |=> st_q.reflect_fail && st_q.reflect_done)
      else $error("measurement failure not flagged");

   chk_standby_write: assert property (@(posedge mclk) disable iff (sys_rst)
      wr && idx == `IDX_PHY_RESET_CTRL && wb_sel_i[0] && !st_q.hw_rst
         |=> ctrl_o.standby == $past(wb_dat_i[`BIT_STANDBY]))
      else $error("standby bit not written");

   chk_link_live: assert property (@(posedge mclk) disable iff (sys_rst)
      rd && idx == `IDX_LINK_STATUS |=> wb_ack_o && wb_dat_o[12] == $past(core_i.link_up))
      else $error("link status not read live");

   chk_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      rd && idx == `IDX_ST_PKT_LEN |=> wb_dat_o[31:11] == 21'h000000)
      else $error("reserved packet length bits not zero");

endmodule : phy_diag_regs

// file: test/phy_diag_regs_bench.sv
// self-checking bench for the diagnostic register bank
// assumes one-cycle wishbone answer and phy core inputs on mclk
module phy_diag_regs_bench
   import phy_diag_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   // bus, core and bookkeeping signals
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   core_status_s core = '0;
   reflect_result_s refl = '0;
   core_ctrl_s ctrl;
   int fail_count = 0;
   int n_compared = 0;
   int n_hw = 0;
   int n_sw = 0;
   int n;
   logic [15:0] rv;
   logic [15:0] v;
   logic [2:0] en;
   logic [2:0] ev;

   phy_diag_regs phy_diag_regs_i (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .core_i(core), .reflect_i(refl), .ctrl_o(ctrl));

   ////////////////////////////////////////////////////////////////////////////////
   // clock and pulse counters
   initial begin
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      n_hw += int'(ctrl.hw_reset === 1'b1);
      n_sw += int'(ctrl.sw_restart === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // comparison, bus cycles and pulses
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic xfer(input logic w, input logic [9:0] idx, input logic [15:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h3;
      wdat <= {16'h0000, d};
      do begin
         @(posedge mclk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rv = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) fail_count++;
   endtask : xfer

   task automatic wr(input logic [9:0] idx, input logic [15:0] d);
      xfer(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [15:0] exp);
      xfer(1'b0, idx, 16'h0000);
      check(rv, exp);
      check(rdat[31:16], 16'h0000);
   endtask : rd

   task automatic evt(input logic [2:0] e, input logic uf);
      @(posedge mclk);
      core.por_done <= e[2];
      core.no_frame <= e[1];
      core.sleep_sig <= e[0];
      core.rx_underflow <= uf;
      @(posedge mclk);
      core.por_done <= 1'b0;
      core.no_frame <= 1'b0;
      core.sleep_sig <= 1'b0;
      core.rx_underflow <= 1'b0;
      @(posedge mclk);
   endtask : evt

   task automatic errs(input int np);
      repeat (np) begin
         @(posedge mclk);
         core.prbs_err <= 1'b1;
      end
      @(posedge mclk);
      core.prbs_err <= 1'b0;
   endtask : errs

   task automatic rdone(input logic f);
      @(posedge mclk);
      refl.done <= 1'b1;
      refl.fail <= f;
      @(posedge mclk);
      refl.done <= 1'b0;
      refl.fail <= 1'b0;
   endtask : rdone

   // drift tolerance per buffer size code
   function automatic logic [2:0] tol(input logic [1:0] s);
      return (s == 2'h0) ? 3'h5 : 3'({1'b0, s} + 3'h1);
   endfunction : tol

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      final_report();
   end

   // main sequence
   initial begin
      void'($urandom(32'hfdc2c713));
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(10'h017, 16'h404d);
      rd(10'h018, 16'h0010);
      rd(10'h01b, 16'h007d);
      rd(10'h01c, 16'h05ee);
      rd(10'h01e, 16'h0000);
      rd(10'h01f, 16'h0000);
      wr(10'h0ff, 16'hffff);
      rd(10'h0ff, 16'h0000);
      for (int s = 0; s < 4; s++) begin
         wr(10'h017, 16'hfffc | 16'(s));
         rd(10'h017, 16'h404c | 16'(s));
         check({13'h0, ctrl.eb_tol_bits}, {13'h0, tol(2'(s))});
         check({14'h0, ctrl.eb_size}, 16'(s));
      end
      evt(3'h0, 1'b1);
      rd(10'h017, 16'h404b);
      rd(10'h017, 16'h404f);
      for (int i = 0; i < 8; i++) begin
         en = 3'($urandom());
         ev = (i == 0) ? 3'h7 : 3'($urandom());
         wr(10'h018, 16'hffe6 | {11'h0, en[2:1], 2'b00, en[0]});
         evt(ev, 1'b0);
         check({15'h0, ctrl.irq}, {15'h0, |(en & ev)});
         rd(10'h018, {3'h0, ev[2:1], 2'b00, ev[0], 3'h0, en[2:1], 2'b00, en[0]});
         check({15'h0, ctrl.irq}, 16'h0000);
      end
      wr(10'h01b, 16'h807d);
      for (int i = 0; i < 4; i++) begin
         n = (i == 0) ? 300 : (i == 1) ? 255 : (i == 3) ? 260 : int'($urandom_range(40, 1));
         core.err_cnt_continuous <= (i == 3);
         v = {8'h00, 8'($urandom())};
         errs(n);
         wr(10'h01b, 16'h8000 | v);
         rd(10'h01b, {(n > 255 && i != 3) ? 8'hff : 8'(n), v[7:0]});
         check({6'h0, ctrl.ipg_bytes}, {6'h0, v[7:0], 2'b00});
      end
      errs(5);
      rd(10'h01b, {8'h04, v[7:0]});
      v = 16'($urandom());
      wr(10'h01c, v);
      rd(10'h01c, {5'h0, v[10:0]});
      check({5'h0, ctrl.pkt_len}, {5'h0, v[10:0]});
      for (int f = 0; f < 2; f++) begin
         wr(10'h01e, 16'h8000);
         rd(10'h01e, 16'h8000);
         check({15'h0, ctrl.reflect_run}, 16'h0001);
         rdone(f[0]);
         rd(10'h01e, {14'h0, 1'b1, f[0]});
         rdone(~f[0]);
         rd(10'h01e, {14'h0, 1'b1, f[0]});
         check({15'h0, ctrl.reflect_run}, 16'h0000);
      end
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom());
         core.link_up <= v[0];
         core.scr_lock <= v[1];
         core.local_rx_ok <= v[2];
         core.remote_rx_ok <= v[3];
         refl.fault <= v[4];
         refl.fault_short <= v[5];
         refl.fault_loc <= v[15:8];
         refl.peak_loc <= $urandom();
         refl.peak_neg <= v[9:6];
         rd(10'h133, {3'h0, v[0], 9'h0bc, v[1], v[2], v[3]});
         rd(10'h16b, {6'h0, v[4], v[5], v[15:8]});
         rd(10'h180, refl.peak_loc[1:0]);
         rd(10'h181, refl.peak_loc[3:2]);
         rd(10'h18a, {1'b0, v[9:6], 11'h0});
      end
      wr(10'h16b, 16'hffff);
      rd(10'h16b, {6'h0, v[4], v[5], v[15:8]});
      wr(10'h01f, 16'h4080);
      rd(10'h01f, 16'h0080);
      check({15'h0, ctrl.standby}, 16'h0001);
      rd(10'h018, {11'h0, en[2:1], 2'b00, en[0]});
      check(n_sw[15:0], 16'h0001);
      wr(10'h01f, 16'h0000);
      check({15'h0, ctrl.standby}, 16'h0000);
      wr(10'h01f, 16'h8000);
      repeat (2) @(posedge mclk);
      check(n_hw[15:0], 16'h0001);
      rd(10'h01c, 16'h05ee);
      rd(10'h018, 16'h0010);
      check({13'h0, ctrl.eb_tol_bits}, 16'h0002);
      final_report();
   end

endmodule : phy_diag_regs_bench
